// ===== design/scp_pkg.sv
package scp_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] ADR_TRIM = 8'h00;
  localparam logic [7:0] ADR_DIV = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0c;
  localparam int REG_N = 4;

  // Source select fuse codes.
  localparam logic [3:0] SRC_EXT = 4'h0;
  localparam logic [3:0] SRC_RC = 4'h2;
  localparam logic [3:0] SRC_LF_LO = 4'h4;
  localparam logic [3:0] SRC_LF_HI = 4'h7;

  // Start-up fuse codes.
  localparam logic [1:0] SUT_NONE = 2'h0;
  localparam logic [1:0] SUT_SHORT = 2'h1;
  localparam logic [1:0] SUT_LONG = 2'h2;
  localparam logic [1:0] SUT_RSVD = 2'h3;

  // Divider register layout.
  localparam int DIV_UNLOCK_BIT = 7;
  localparam logic [7:0] DIV_UNLOCK_PAT = 8'h80;
  localparam logic [3:0] DIV_SEL_ONE = 4'h0;
  localparam logic [3:0] DIV_SEL_FUSE8 = 4'h3;
  localparam logic [3:0] DIV_SEL_MAX = 4'h8;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

  // Control and status layout.
  localparam int CTRL_TMR_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_SRC_LSB = 8;
  localparam int STAT_DIV_LSB = 12;
  localparam int STAT_BAD_BIT = 16;

  // Start-up counts, in ticks of the oscillator that times them.
  localparam int CNT_W = 17;
  localparam logic [16:0] RST_CK = 17'h0000e;
  localparam logic [16:0] WAKE_SHORT_CK = 17'h00006;
  localparam logic [16:0] WAKE_LF_SHORT_CK = 17'h00400;
  localparam logic [16:0] WDT_SHORT_TICKS = 17'h01000;
  localparam int WDT_LONG_TICKS = 65536;
  localparam int WAKE_LF_LONG_CK = 32768;

  // Nominal RC rate and maximum external clock rate.
  localparam int RC_NOMINAL_KHZ = 8000;
  localparam int EXT_MAX_KHZ = 16000;

  typedef enum logic [4:0] {
    ST_HOLD = 5'h01,
    ST_WDT = 5'h02,
    ST_CKCNT = 5'h04,
    ST_RUN = 5'h08,
    ST_SLEEP = 5'h10
  } scp_state_t;

  typedef struct packed {
    logic [3:0] clock_source_select_fuses;
    logic [1:0] startup_time_fuses;
    logic divide_by_eight_fuse;
    logic clock_output_fuse;
  } scp_fuse_t;

  typedef struct packed {
    logic lf_xtal;
    logic rc;
    logic ext;
  } scp_src_t;

  typedef struct packed {
    logic io;
    logic adc;
    logic cpu;
    logic flash;
  } scp_clk_en_t;

endpackage

// ===== design/scp_tick_sync.sv
`timescale 1ns/1ns
module scp_tick_sync (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Pin and its rising edge.
  input wire logic pin_in,
  output logic tick
);

  logic meta_r, meta_nxt;
  logic sync_r, sync_nxt;
  logic prev_r, prev_nxt;
  logic tick_r, tick_nxt;

  // The edge detector reads the second stage and its delayed copy, never the first.
  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
    tick_nxt = sync_r & ~prev_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Stages reset high, so a pin already high at release is not taken
      // for a fresh edge.
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
      tick_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

// ===== design/scp_prescale.sv
`timescale 1ns/1ns
module scp_prescale (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Requested and active division select.
  input wire logic [3:0] sel_req,
  output logic [3:0] sel_act,
  // One pulse per divided period.
  output logic tick
);

  logic [7:0] cnt_r, cnt_nxt;
  logic [3:0] act_r, act_nxt;
  logic tick_r, tick_nxt;
  logic [7:0] mask;

  // A new factor is taken only at the end of a period, so no period is
  // ever shorter than both the old and the new one.
  always_comb begin
    mask = 8'((9'h001 << act_r) - 9'h001);
    tick_nxt = ((cnt_r & mask) == mask);
    cnt_nxt = tick_nxt ? 8'h00 : 8'(cnt_r + 8'h01);
    act_nxt = tick_nxt ? sel_req : act_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 8'h00;
      act_r <= sel_req;
      // Ticking on every reset cycle keeps the clock pin alive while reset
      // is held; the division factor only applies after release.
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign sel_act = act_r;
  assign tick = tick_r;

endmodule

// ===== design/scp_top.sv
// Summary of operation
// R1: Source codes 0100 to 0111 select the low-frequency watch crystal.
// R2: Watch crystal reset delay: 14 clocks, plus 4.1 or 65 ms; 11 reserved.
// R3: Watch crystal wake takes 1K clocks for 0100/0110, 32K for 0101/0111.
// R4: Source code 0010 selects the internal 8 MHz RC oscillator.
// R5: During reset the factory calibration byte is loaded into the trim.
// R6: RC wake takes 6 clocks; reset delay 14 clocks plus fuse-chosen extra.
// R7: The watchdog oscillator times the reset time-out for every source.
// R8: The timer oscillator is usable only while the RC oscillator runs.
// R9: Seven trim bits raise RC frequency monotonically from zero to 0x7f.
// R10: Software keeps trim under 10% above nominal while writing memory.
// R11: Source code 0000 selects an external clock of 0 to 16 MHz.
// R12: External clock wake takes 6 clocks; reset delay as for the RC.
// R13: The external clock changes under 2% per cycle, else reset is held; no logic here checks the clock or holds reset.
// R14: The clock output fuse drives the divided clock on the pin, even in reset; in reset the pin toggles every cycle, undivided.
// R15: One prescale factor divides io, adc, cpu and flash clocks alike.
// R16: Divider register: unlock bit 7, select bits 3..0, bits 6..4 zero.
// R17: Unlock alone, then write select within four cycles; unlock self-clears.
// R18: Select codes 0 to 8 divide by 1 to 256; 9 to 15 are reserved.
// R19: Reset loads select 0011 with the divide-by-eight fuse, else 0000.
// R20: Fuse values are sampled at reset and held static afterwards.
`timescale 1ns/1ns
module scp_top #(
  parameter int P_WDT_LONG = scp_pkg::WDT_LONG_TICKS,
  parameter int P_WAKE_LONG = scp_pkg::WAKE_LF_LONG_CK
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Static configuration.
  input wire scp_pkg::scp_fuse_t fuses,
  input wire logic [7:0] cal_byte,
  // Oscillator pins, asynchronous.
  input wire logic osc_clk_pin,
  input wire logic wdt_osc_pin,
  // Sleep control from the core.
  input wire logic sleep_req,
  input wire logic wake_req,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Clock enables and oscillator control.
  output scp_pkg::scp_clk_en_t clk_en,
  output scp_pkg::scp_src_t osc_sel,
  output logic [6:0] rc_trim_value,
  output logic timer_osc_en,
  // Clock output pin.
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe
);

  scp_pkg::scp_fuse_t fuse_r;
  scp_pkg::scp_state_t state_r, state_nxt;
  scp_pkg::scp_src_t src_r, src_nxt;
  scp_pkg::scp_clk_en_t en_r, en_nxt;
  logic [scp_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [7:0] trim_r, trim_nxt;
  logic [3:0] div_sel_r, div_sel_nxt;
  logic [2:0] unlock_r, unlock_nxt;
  logic ctrl_r, ctrl_nxt, ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic clock_output_pin_r, clock_output_pin_nxt;
  logic clock_output_pin_oe_r, clock_output_pin_oe_nxt;
  logic tmr_r, tmr_nxt;
  logic [1:0] pin_in, tick;
  logic presc_tick;
  logic [3:0] div_act;
  logic [scp_pkg::REG_N-1:0] hit;
  logic wr, bad;

  // One-hot register decode, shared by reads and writes.
  function automatic logic [scp_pkg::REG_N-1:0] reg_hit(
    input logic [7:0] adr
  );
    reg_hit = {adr == scp_pkg::ADR_STAT, adr == scp_pkg::ADR_CTRL,
               adr == scp_pkg::ADR_DIV, adr == scp_pkg::ADR_TRIM};
  endfunction

  // Wake-up count in ticks of the selected oscillator.
  function automatic logic [scp_pkg::CNT_W-1:0] wake_count(
    input scp_pkg::scp_fuse_t f
  );
    logic [3:0] cs;
    cs = f.clock_source_select_fuses;
    if (cs >= scp_pkg::SRC_LF_LO && cs <= scp_pkg::SRC_LF_HI) begin
      wake_count = cs[0] ? scp_pkg::CNT_W'(P_WAKE_LONG) :
                   scp_pkg::WAKE_LF_SHORT_CK; // R3
    end else begin
      wake_count = scp_pkg::WAKE_SHORT_CK; // R6 R12
    end
  endfunction

  assign pin_in = {wdt_osc_pin, osc_clk_pin};

  // Index 0 counts source clocks, index 1 watchdog oscillator periods.
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      scp_tick_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(pin_in[i]),
        .tick(tick[i])
      );
    end
  endgenerate

  scp_prescale u_presc (
    .clk(clk),
    .sys_rst(sys_rst),
    .sel_req(div_sel_r),
    .sel_act(div_act),
    .tick(presc_tick)
  );

  // Register bus. A request is acknowledged one cycle after it appears
  // and writes take effect on the edge that samples the acknowledge.
  always_comb begin
    hit = reg_hit(wb_adr_i);
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];
    dat_nxt = 32'h00000000;
    if (ack_nxt && !wb_we_i) begin
      if (hit[0]) begin
        dat_nxt[7:0] = trim_r;
      end
      if (hit[1]) begin
        dat_nxt[scp_pkg::DIV_UNLOCK_BIT] = (unlock_r != 3'h0); // R16
        dat_nxt[3:0] = div_sel_r;
      end
      if (hit[2]) begin
        dat_nxt[scp_pkg::CTRL_TMR_BIT] = ctrl_r;
      end
      if (hit[3]) begin
        dat_nxt[scp_pkg::STAT_STATE_LSB +: 5] = state_r;
        dat_nxt[scp_pkg::STAT_SRC_LSB +: 3] = src_r;
        dat_nxt[scp_pkg::STAT_DIV_LSB +: 4] = div_act;
        dat_nxt[scp_pkg::STAT_BAD_BIT] = bad;
      end
    end
    trim_nxt = trim_r;
    ctrl_nxt = ctrl_r;
    div_sel_nxt = div_sel_r;
    // The unlock window counts down on its own; a second unlock write
    // while it runs neither extends nor clears it.
    unlock_nxt = (unlock_r != 3'h0) ? 3'(unlock_r - 3'h1) : 3'h0; // R17
    if (wr && hit[0]) begin
      trim_nxt = wb_dat_i[7:0]; // R9
    end
    if (wr && hit[2]) begin
      ctrl_nxt = wb_dat_i[scp_pkg::CTRL_TMR_BIT];
    end
    if (wr && hit[1]) begin
      if (wb_dat_i[7:0] == scp_pkg::DIV_UNLOCK_PAT) begin
        if (unlock_r == 3'h0) begin
          unlock_nxt = scp_pkg::UNLOCK_CYCLES; // R17
        end
      end else if (!wb_dat_i[scp_pkg::DIV_UNLOCK_BIT] &&
                   unlock_r != 3'h0) begin
        unlock_nxt = 3'h0; // R17
        // Reserved codes are dropped so the divider never leaves 1..256.
        if (wb_dat_i[3:0] <= scp_pkg::DIV_SEL_MAX) begin
          div_sel_nxt = wb_dat_i[3:0]; // R18
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
      trim_r <= cal_byte; // R5
      ctrl_r <= 1'b0;
      unlock_r <= 3'h0; // R16
      div_sel_r <= fuses.divide_by_eight_fuse ? scp_pkg::DIV_SEL_FUSE8 :
                   scp_pkg::DIV_SEL_ONE; // R19
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      trim_r <= trim_nxt;
      ctrl_r <= ctrl_nxt;
      unlock_r <= unlock_nxt;
      div_sel_r <= div_sel_nxt;
    end
  end

  // Fuses are caught while reset is held and never change afterwards.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fuse_r <= fuses; // R20
    end
  end

  // Start-up sequencer. The real-time part runs on the watchdog
  // oscillator, the clock-count part on the selected source.
  always_comb begin
    src_nxt.lf_xtal = fuse_r.clock_source_select_fuses >= scp_pkg::SRC_LF_LO
      && fuse_r.clock_source_select_fuses <= scp_pkg::SRC_LF_HI; // R1
    src_nxt.rc = fuse_r.clock_source_select_fuses == scp_pkg::SRC_RC; // R4
    src_nxt.ext =
      fuse_r.clock_source_select_fuses == scp_pkg::SRC_EXT; // R11
    // Unsupported sources and the reserved start-up code halt the chip.
    bad = !(src_nxt.lf_xtal | src_nxt.rc | src_nxt.ext) ||
          fuse_r.startup_time_fuses == scp_pkg::SUT_RSVD;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      scp_pkg::ST_HOLD: begin
        if (!bad) begin
          if (fuse_r.startup_time_fuses == scp_pkg::SUT_NONE) begin
            state_nxt = scp_pkg::ST_CKCNT;
            cnt_nxt = scp_pkg::RST_CK; // R2 R6 R12
          end else begin
            state_nxt = scp_pkg::ST_WDT;
            cnt_nxt = (fuse_r.startup_time_fuses == scp_pkg::SUT_SHORT) ?
                      scp_pkg::WDT_SHORT_TICKS :
                      scp_pkg::CNT_W'(P_WDT_LONG); // R2 R6 R12
          end
        end
      end
      scp_pkg::ST_WDT: begin
        if (cnt_r == '0) begin
          state_nxt = scp_pkg::ST_CKCNT;
          cnt_nxt = scp_pkg::RST_CK;
        end else if (tick[1]) begin
          cnt_nxt = scp_pkg::CNT_W'(cnt_r - 1'b1); // R7
        end
      end
      scp_pkg::ST_CKCNT: begin
        if (cnt_r == '0) begin
          state_nxt = scp_pkg::ST_RUN;
        end else if (tick[0]) begin
          cnt_nxt = scp_pkg::CNT_W'(cnt_r - 1'b1);
        end
      end
      scp_pkg::ST_RUN: begin
        if (sleep_req) begin
          state_nxt = scp_pkg::ST_SLEEP;
        end
      end
      scp_pkg::ST_SLEEP: begin
        if (wake_req) begin
          state_nxt = scp_pkg::ST_CKCNT;
          cnt_nxt = wake_count(fuse_r); // R3 R6 R12
        end
      end
      default: begin
        state_nxt = scp_pkg::ST_HOLD;
      end
    endcase
  end

  // Outputs. The clock output keeps toggling in every state, reset
  // included, because the prescaler is never gated by the sequencer.
  always_comb begin
    en_nxt.io = presc_tick & (state_r == scp_pkg::ST_RUN); // R15
    en_nxt.adc = en_nxt.io;
    en_nxt.cpu = en_nxt.io;
    en_nxt.flash = en_nxt.io;
    clock_output_pin_nxt = presc_tick; // R14
    if (clock_output_pin_r) begin
      clock_output_pin_nxt = !presc_tick;
    end
    clock_output_pin_oe_nxt = fuse_r.clock_output_fuse; // R14
    tmr_nxt = ctrl_r & src_r.rc; // R8
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= scp_pkg::ST_HOLD;
      cnt_r <= '0;
      src_r <= '0;
      en_r <= '0;
      clock_output_pin_r <= clock_output_pin_nxt; // R14
      clock_output_pin_oe_r <= fuses.clock_output_fuse; // R14
      tmr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      src_r <= src_nxt;
      en_r <= en_nxt;
      clock_output_pin_r <= clock_output_pin_nxt;
      clock_output_pin_oe_r <= clock_output_pin_oe_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign clk_en = en_r;
  assign osc_sel = src_r;
  assign rc_trim_value = trim_r[6:0]; // R9
  assign timer_osc_en = tmr_r;
  assign clock_output_pin_o = clock_output_pin_r;
  assign clock_output_pin_oe = clock_output_pin_oe_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_unlock_window: // R17
  assert property (unlock_r == scp_pkg::UNLOCK_CYCLES |->
                   ##4 unlock_r == 3'h0)
    else $error("Unlock bit outlived its window.");

  a_sel_needs_unlock: // R17
  assert property (div_sel_r != $past(div_sel_r) |->
                   $past(unlock_r) != 3'h0 && unlock_r == 3'h0)
    else $error("Division select changed without unlock.");

  a_sel_legal: // R18
  assert property (div_sel_r <= scp_pkg::DIV_SEL_MAX)
    else $error("Division select holds a reserved code.");

  a_reset_sel: // R19
  assert property ($fell(sys_rst) |-> div_sel_r ==
                   (fuse_r.divide_by_eight_fuse ? scp_pkg::DIV_SEL_FUSE8 :
                    scp_pkg::DIV_SEL_ONE))
    else $error("Division select reset value wrong.");

  a_trim_load: // R5
  assert property ($fell(sys_rst) |-> trim_r == $past(cal_byte))
    else $error("Calibration byte not loaded at reset.");

  a_div_readback: // R16
  assert property (ack_r && !wb_we_i && $past(hit[1]) |->
                   dat_r[6:4] == 3'h0 && dat_r[31:8] == 24'h000000)
    else $error("Divider read shows nonzero reserved bits.");

  a_src_decode: // R1
  assert property ($past(!bad) && state_r != scp_pkg::ST_HOLD |->
                   $onehot(src_r))
    else $error("Running with no single source selected.");

  a_timer_osc_rc: // R8
  assert property (timer_osc_en |-> src_r.rc)
    else $error("Timer oscillator enabled without the RC source.");

  a_clock_output_pin_fuse: // R14
  assert property (clock_output_pin_oe == fuse_r.clock_output_fuse)
    else $error("Clock output enable disagrees with its fuse.");

  a_en_common: // R15
  assert property (clk_en.io |-> clk_en.cpu && clk_en.adc &&
                   clk_en.flash && $past(state_r) == scp_pkg::ST_RUN)
    else $error("Clock enables split or fire outside run.");

  a_rst_ck: // R2
  assert property ($past(state_r) == scp_pkg::ST_WDT &&
                   state_r == scp_pkg::ST_CKCNT |-> cnt_r == scp_pkg::RST_CK)
    else $error("Reset clock count not loaded.");

  a_wake_count: // R3
  assert property ($past(state_r) == scp_pkg::ST_SLEEP &&
                   state_r == scp_pkg::ST_CKCNT |->
                   cnt_r == wake_count(fuse_r))
    else $error("Wake-up count wrong for the source.");

  a_fuse_static: // R20
  assert property ($past(!sys_rst) |-> $stable(fuse_r))
    else $error("Fuse image changed outside reset.");

endmodule

// ===== test/scp_osc_model.sv
`timescale 1ns/1ns
module scp_osc_model #(
  parameter int P_OSC_HALF = 35,
  parameter int P_WDT_HALF = 40
) (
  // Oscillator pins.
  output logic osc_clk_pin,
  output logic wdt_osc_pin
);
  // A fixed half period keeps the cycle-to-cycle change at zero, and the
  // 70 ns period stays inside the accepted external clock range.
  initial begin
    osc_clk_pin = 1'b0;
    forever #(P_OSC_HALF) osc_clk_pin = ~osc_clk_pin;
  end
  // The watchdog oscillator runs whatever the system source is.
  initial begin
    wdt_osc_pin = 1'b0;
    forever #(P_WDT_HALF) wdt_osc_pin = ~wdt_osc_pin;
  end
endmodule

// ===== test/tb.sv
`timescale 1ns/1ns
module tb;
  logic clk, sys_rst, osc_clk_pin, wdt_osc_pin, sleep_req, wake_req;
  scp_pkg::scp_fuse_t fuses;
  logic [7:0] cal_byte, wb_adr_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, timer_osc_en;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  scp_pkg::scp_clk_en_t clk_en;
  scp_pkg::scp_src_t osc_sel;
  logic [6:0] rc_trim_value;
  logic clock_output_pin_o, clock_output_pin_oe;
  int errors, num_checks;

  scp_osc_model osc (.osc_clk_pin(osc_clk_pin), .wdt_osc_pin(wdt_osc_pin));

  // Short watchdog and wake counts keep the run brief.
  scp_top #(.P_WDT_LONG(40), .P_WAKE_LONG(40)) DUT (
    .clk(clk), .sys_rst(sys_rst), .fuses(fuses), .cal_byte(cal_byte),
    .osc_clk_pin(osc_clk_pin), .wdt_osc_pin(wdt_osc_pin),
    .sleep_req(sleep_req), .wake_req(wake_req),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clk_en(clk_en),
    .osc_sel(osc_sel), .rc_trim_value(rc_trim_value),
    .timer_osc_en(timer_osc_en), .clock_output_pin_o(clock_output_pin_o),
    .clock_output_pin_oe(clock_output_pin_oe));

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, {24'h0, d}, r);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(nm, e, r);
  endtask

  task automatic do_reset(input logic [7:0] f);
    logic p0;
    sys_rst <= 1'b1;
    fuses <= f;
    repeat (7) @(posedge clk);
    p0 = clock_output_pin_o;
    chk("pin oe", {31'h0, f[0]}, {31'h0, clock_output_pin_oe});
    chk("trim in reset", 32'h5a, {25'h0, rc_trim_value});
    chk("source in reset", 32'h0, {29'h0, osc_sel});
    @(posedge clk);
    chk("pin in reset", {31'h0, ~p0}, {31'h0, clock_output_pin_o});
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_en(output int n);
    n = 0;
    while (clk_en.cpu !== 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask

  // Reset delay, source, sleep and wake for one fuse setting.
  task automatic start_case(input logic [7:0] f, input int wdt,
                            input int wake, input logic [2:0] es);
    int n, x;
    logic [31:0] r;
    do_reset(f);
    wait_en(n);
    x = wdt * 8 + 14 * 7;
    chk("reset delay", 32'h1, {31'h0, n >= x - 16 && n <= x + 30});
    chk("source", {29'h0, es}, {29'h0, osc_sel});
    wr(scp_pkg::ADR_CTRL, 8'h01);
    repeat (2) @(posedge clk);
    chk("timer osc", {31'h0, es[1]}, {31'h0, timer_osc_en});
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    rdc("status", scp_pkg::ADR_STAT, {21'h0, es, 3'h0, 5'h10});
    n = 0;
    repeat (20) begin
      @(posedge clk);
      if (clk_en.cpu === 1'b1) n++;
    end
    chk("sleep enables", 32'h0, 32'(n));
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    wait_en(n);
    x = wake * 7;
    chk("wake delay", 32'h1, {31'h0, n >= x - 12 && n <= x + 30});
  endtask

  task automatic bad_case(input logic [7:0] f);
    logic [31:0] r;
    do_reset(f);
    repeat (300) @(posedge clk);
    xfer(1'b0, scp_pkg::ADR_STAT, 32'h0, r);
    chk("bad status", 32'h10001, r & 32'h1001f);
    chk("bad enables", 32'h0, {28'h0, clk_en});
  endtask

  task automatic period(output int n, output int p);
    while (clk_en.cpu !== 1'b1) @(posedge clk);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (clk_en.cpu !== 1'b1);
    chk("enables", 32'hf, {28'h0, clk_en});
    while (clock_output_pin_o !== 1'b0) @(posedge clk);
    while (clock_output_pin_o !== 1'b1) @(posedge clk);
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while (clock_output_pin_o !== 1'b0);
    do begin
      @(posedge clk);
      p++;
    end while (clock_output_pin_o !== 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The run needs about 50k cycles; the limit stops a hang at 80k.
  initial begin
    #800000;
    errors++;
    close_out();
  end

  initial begin
    int n, p;
    errors = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    fuses = '0;
    cal_byte = 8'h5a;
    sleep_req = 1'b0;
    wake_req = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    @(posedge clk);
    start_case(8'h00, 0, 6, 3'b001);
    start_case(8'h40, 0, 1024, 3'b100);
    start_case(8'h78, 40, 40, 3'b100);
    start_case(8'h24, 4096, 6, 3'b010);
    bad_case(8'h30);
    bad_case(8'h2c);
    do_reset(8'h23);
    rdc("trim", scp_pkg::ADR_TRIM, 32'h5a);
    rdc("div", scp_pkg::ADR_DIV, 32'h03);
    // No memory write is in progress here, so the top trim is allowed.
    wr(scp_pkg::ADR_TRIM, 8'h7f);
    chk("trim out", 32'h7f, {25'h0, rc_trim_value});
    rdc("trim", scp_pkg::ADR_TRIM, 32'h7f);
    rdc("unmapped", 8'h10, 32'h0);
    wr(scp_pkg::ADR_DIV, 8'h80);
    rdc("unlock", scp_pkg::ADR_DIV, 32'h83);
    repeat (4) @(posedge clk);
    rdc("relock", scp_pkg::ADR_DIV, 32'h03);
    wr(scp_pkg::ADR_DIV, 8'h80);
    wr(scp_pkg::ADR_DIV, 8'h75);
    rdc("div", scp_pkg::ADR_DIV, 32'h05);
    wr(scp_pkg::ADR_DIV, 8'h07);
    rdc("locked", scp_pkg::ADR_DIV, 32'h05);
    wr(scp_pkg::ADR_DIV, 8'h80);
    wr(scp_pkg::ADR_DIV, 8'h09);
    rdc("reserved", scp_pkg::ADR_DIV, 32'h05);
    wr(scp_pkg::ADR_DIV, 8'h80);
    repeat (6) @(posedge clk);
    wr(scp_pkg::ADR_DIV, 8'h01);
    rdc("late", scp_pkg::ADR_DIV, 32'h05);
    wr(scp_pkg::ADR_DIV, 8'h81);
    wr(scp_pkg::ADR_DIV, 8'h01);
    rdc("impure", scp_pkg::ADR_DIV, 32'h05);
    for (int s = 0; s <= 8; s++) begin
      wr(scp_pkg::ADR_DIV, 8'h80);
      wr(scp_pkg::ADR_DIV, 8'(s));
      repeat (600) @(posedge clk);
      period(n, p);
      chk("div period", 32'(1 << s), 32'(n));
      chk("pin period", 32'(2 << s), 32'(p));
    end
    close_out();
  end
endmodule
